// ===== sdip_chk.sv
`timescale 1ns/1ps
module sdip_chk (
    input wire        clk_in,         // clock
    input wire        rst_in,         // reset
    input wire [15:0] addr_in,        // address
    input wire [7:0]  data_in,        // write data
    input wire        mreq_n_in,      // memory request
    input wire        iorq_n_in,      // i/o request
    input wire        rd_n_in,        // read strobe
    input wire        wr_n_in,        // write strobe
    input wire        m1_n_in,        // ack qualifier
    input wire        rom_sel_n_out,  // rom select
    input wire        ram_sel_n_out,  // ram select
    input wire [7:0]  bank_sel_n_out, // bank selects
    input wire        rom_ovl_out     // overlay state
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire io = !iorq_n_in && m1_n_in && !(rd_n_in && wr_n_in);
    property p_ovl_rst; $past(rst_in) |-> rom_ovl_out; endproperty
    property p_rom; !mreq_n_in && !addr_in[15] && rom_ovl_out
        |=> !rom_sel_n_out && ram_sel_n_out; endproperty
    property p_ram; !mreq_n_in && addr_in[15]
        |=> rom_sel_n_out && !ram_sel_n_out; endproperty
    property p_excl; rom_sel_n_out || ram_sel_n_out; endproperty
    property p_mem; iorq_n_in |=> &bank_sel_n_out; endproperty
    property p_bank; io && addr_in[7:6] == 2'h0
        |=> bank_sel_n_out == ~(8'h01 << $past(addr_in[5:3])); endproperty
    property p_hi; io && addr_in[7:6] != 2'h0 |=> &bank_sel_n_out; endproperty
    property p_ovl_wr; io && !wr_n_in && addr_in[7:0] == 8'h18
        |-> ##2 rom_ovl_out == $past(data_in[0], 2); endproperty
    a_ovl_rst: assert property (p_ovl_rst) else $error("overlay off");
    a_rom: assert property (p_rom) else $error("rom not selected");
    a_ram: assert property (p_ram) else $error("ram not selected");
    a_excl: assert property (p_excl) else $error("rom and ram both");
    a_mem: assert property (p_mem) else $error("bank on mem cycle");
    a_bank: assert property (p_bank) else $error("wrong bank");
    a_hi: assert property (p_hi) else $error("bank above 3F");
    a_ovl_wr: assert property (p_ovl_wr) else $error("overlay write");
    c_wr: cover property (io && !wr_n_in && addr_in[7:0] == 8'h18);
    c_bank: cover property (io && addr_in[7:3] == 5'h07);
    c_ack: cover property (!iorq_n_in && !m1_n_in);
endmodule
bind sdip_glue sdip_chk sdip_chk_inst (.*);

// ===== sdip_consts.vh
// How it works
// - reset turns boot ROM overlay on
// - port write loads overlay from data bit 0 anytime
// - low 32K goes ROM or RAM, never both
// - ROM decode passes fourteen address bits
// - display memory reached only through ports
// - bank selects only on I/O cycles
// - eight active-low selects of eight ports
// - bank n covers ports 8n to 8n+7
// - banks four to seven go to expansion
// - programmed I/O only, no DMA
// - acknowledge returns mode 2 vector byte
// - vector table FB00-FB0F filled by software
// - eight sources ranked, disk request highest
// - disk gives data and completion sources
// - video raises source on command done
// - keyboard and timer have own sources
// - three lowest-ranked inputs, 5 to 7, left for expansion
// - status read shows pending flag and raw sources 0-6
// - control registers reset to defined setup
`ifndef SDIP_CONSTS_VH
`define SDIP_CONSTS_VH

// ----------------------------------------------------------------
// memory decode
// ----------------------------------------------------------------
`define SDIP_A_HALF        15
`define SDIP_ROM_AW        14

// ----------------------------------------------------------------
// i/o decode
// ----------------------------------------------------------------
`define SDIP_IO_HI         7
`define SDIP_IO_LO         6
`define SDIP_BANK_HI       5
`define SDIP_BANK_LO       3
`define SDIP_IO_FREE       2'h0

// ----------------------------------------------------------------
// internal ports
// ----------------------------------------------------------------
`define SDIP_PORT_STATUS   8'h18
`define SDIP_PORT_CTRL1    8'h18
`define SDIP_PORT_CTRL2    8'h1D
`define SDIP_PORT_DISP_RD  8'h0D
`define SDIP_PORT_DISP_WR  8'h1C

// ----------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------
`define SDIP_CTRL1_ROM_BIT 0
`define SDIP_CTRL1_RST     8'h01
`define SDIP_CTRL2_RST     8'hFF
`define SDIP_STATUS_PEND   7

// ----------------------------------------------------------------
// interrupt sources, index 0 ranks highest
// ----------------------------------------------------------------
`define SDIP_SRC_DISK_DRQ  3'h0
`define SDIP_SRC_DISK_DONE 3'h1
`define SDIP_SRC_VIDEO     3'h2
`define SDIP_SRC_KEYBOARD  3'h3
`define SDIP_SRC_TIMER     3'h4
`define SDIP_SRC_CARD_ONE  3'h5
`define SDIP_SRC_CARD_TWO  3'h6
`define SDIP_SRC_EXP_BUS   3'h7

`endif

// ===== sdip_cpu_model.sv
`timescale 1ns/1ps
module sdip_cpu_model (
    input  wire        clk_in,     // clock
    input  wire [7:0]  rd_data_in, // read data
    output reg  [15:0] addr_out,   // address
    output reg  [7:0]  data_out,   // write data
    output reg         mreq_n_out, // memory request
    output reg         iorq_n_out, // i/o request
    output reg         rd_n_out,   // read strobe
    output reg         wr_n_out,   // write strobe
    output reg         m1_n_out    // ack qualifier
);
    initial begin
        {mreq_n_out, iorq_n_out, rd_n_out, wr_n_out, m1_n_out} = 5'h1F;
        {addr_out, data_out} = 24'h000000;
    end
    // kind bit0 i/o, bit1 write, bit2 acknowledge
    task cyc(input [2:0] k, input [15:0] a, input [7:0] d, output [7:0] q);
        begin
            @(posedge clk_in);
            addr_out <= a;
            data_out <= d;
            mreq_n_out <= k[0] | k[2];
            iorq_n_out <= ~(k[0] | k[2]);
            rd_n_out <= k[1] | k[2];
            wr_n_out <= ~k[1];
            m1_n_out <= ~k[2];
            repeat (2) @(posedge clk_in);
            q = rd_data_in;
            {mreq_n_out, iorq_n_out, rd_n_out, wr_n_out, m1_n_out} <= 5'h1F;
            addr_out <= ~a;
            data_out <= ~d;
        end
    endtask
endmodule

// ===== sdip_glue.v
`timescale 1ns/1ps
`include "sdip_consts.vh"

module sdip_glue #(
    parameter ROM_AW = `SDIP_ROM_AW
) (
    input  wire              clk_in,        // 20 MHz system clock
    input  wire              rst_in,        // async reset, active high
    input  wire [15:0]       addr_in,       // processor address
    input  wire [7:0]        data_in,       // processor write data
    input  wire              mreq_n_in,     // memory request, low
    input  wire              iorq_n_in,     // i/o request, low
    input  wire              rd_n_in,       // read strobe, low
    input  wire              wr_n_in,       // write strobe, low
    input  wire              m1_n_in,       // opcode fetch / ack, low
    input  wire              disk_data_request,      // source 0
    input  wire              disk_command_complete,  // source 1
    input  wire              video_done_in,          // source 2
    input  wire              keyboard_data_in,       // source 3
    input  wire              timer_tick_in,          // source 4
    input  wire              expansion_card_one,     // source 5
    input  wire              expansion_card_two,     // source 6
    input  wire              expansion_bus_connector,// source 7
    output reg               rom_sel_n_out, // boot ROM select, low
    output reg               ram_sel_n_out, // system RAM select, low
    output reg  [ROM_AW-1:0] rom_addr_out,  // boot ROM address
    output reg  [7:0]        bank_sel_n_out,// bank selects 0..7, low
    output reg               disp_rd_n_out, // display buffer read, low
    output reg               disp_wr_n_out, // display buffer write, low
    output reg               int_n_out,     // interrupt request, low
    output reg  [7:0]        data_out,      // read / vector data
    output reg               data_oe_out,   // drives data bus, high
    output reg               rom_ovl_out    // overlay state
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function port_hit;
        input [15:0] a;
        input [7:0]  p;
        begin
            port_hit = (a[7:0] == p);
        end
    endfunction

    function [2:0] pri_idx;
        input [7:0] v;
        integer i;
        begin
            pri_idx = 3'h0;
            for (i = 7; i >= 0; i = i - 1) begin
                if (v[i])
                    pri_idx = i[2:0];
            end
        end
    endfunction

    localparam ACK_IDLE = 1'b0;
    localparam ACK_BUSY = 1'b1;

    reg        ack_state_q;
    reg        ack_state_d;
    reg  [7:0] ctrl1_q;
    reg  [7:0] ctrl2_q;
    reg        was_wr_q;

    wire [7:0] src_raw = {expansion_bus_connector,
                          expansion_card_two,
                          expansion_card_one,
                          timer_tick_in,
                          keyboard_data_in,
                          video_done_in,
                          disk_command_complete,
                          disk_data_request};
    wire [7:0] pend    = src_raw & ctrl2_q;
    wire       any_pend = |pend;
    wire       overlay = ctrl1_q[`SDIP_CTRL1_ROM_BIT];

    wire mem_cyc = ~mreq_n_in & (~rd_n_in | ~wr_n_in);
    wire io_cyc  = ~iorq_n_in & m1_n_in & (~rd_n_in | ~wr_n_in);
    wire io_rd   = io_cyc & ~rd_n_in;
    wire io_wr   = io_cyc & ~wr_n_in;
    wire ack_cyc = ~iorq_n_in & ~m1_n_in;
    wire io_low  = (addr_in[`SDIP_IO_HI:`SDIP_IO_LO] == `SDIP_IO_FREE);
    wire [2:0] bank = addr_in[`SDIP_BANK_HI:`SDIP_BANK_LO];
    wire wr_edge = io_wr & ~was_wr_q;

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl1_q  <= `SDIP_CTRL1_RST;
            ctrl2_q  <= `SDIP_CTRL2_RST;
            was_wr_q <= 1'b0;
        end else begin
            was_wr_q <= io_wr;
            if (wr_edge && port_hit(addr_in, `SDIP_PORT_CTRL1))
                ctrl1_q <= data_in;
            if (wr_edge && port_hit(addr_in, `SDIP_PORT_CTRL2))
                ctrl2_q <= data_in;
        end
    end

    // ----------------------------------------------------------------
    // memory and i/o selects
    // ----------------------------------------------------------------
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rom_sel_n_out  <= 1'b1;
            ram_sel_n_out  <= 1'b1;
            rom_addr_out   <= {ROM_AW{1'b0}};
            bank_sel_n_out <= 8'hFF;
            disp_rd_n_out  <= 1'b1;
            disp_wr_n_out  <= 1'b1;
            rom_ovl_out    <= 1'b1;
        end else begin
            rom_ovl_out   <= overlay;
            rom_addr_out  <= addr_in[ROM_AW-1:0];
            rom_sel_n_out <= ~(mem_cyc & ~addr_in[`SDIP_A_HALF]
                               & overlay);
            ram_sel_n_out <= ~(mem_cyc & (addr_in[`SDIP_A_HALF]
                               | ~overlay));
            bank_sel_n_out <= 8'hFF;
            if (io_cyc && io_low)
                bank_sel_n_out[bank] <= 1'b0;
            disp_rd_n_out <= ~(io_rd
                & port_hit(addr_in, `SDIP_PORT_DISP_RD));
            disp_wr_n_out <= ~(io_wr
                & port_hit(addr_in, `SDIP_PORT_DISP_WR));
        end
    end

    // ----------------------------------------------------------------
    // interrupt acknowledge
    // ----------------------------------------------------------------
    always @* begin
        ack_state_d = ack_state_q;
        case (ack_state_q)
            ACK_IDLE: if (ack_cyc) ack_state_d = ACK_BUSY;
            ACK_BUSY: if (!ack_cyc) ack_state_d = ACK_IDLE;
            default:  ack_state_d = ACK_IDLE;
        endcase
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_state_q <= ACK_IDLE;
            int_n_out   <= 1'b1;
            data_out    <= 8'h00;
            data_oe_out <= 1'b0;
        end else begin
            ack_state_q <= ack_state_d;
            int_n_out   <= ~any_pend;
            if (ack_state_q == ACK_IDLE && ack_cyc) begin
                data_out    <= {4'h0, pri_idx(pend), 1'b0};
                data_oe_out <= any_pend;
            end else if (ack_state_q == ACK_BUSY) begin
                data_oe_out <= data_oe_out & ack_cyc;
            end else if (io_rd
                         && port_hit(addr_in, `SDIP_PORT_STATUS)) begin
                data_out    <= {any_pend, src_raw[6:0]};
                data_oe_out <= 1'b1;
            end else begin
                data_oe_out <= 1'b0;
            end
        end
    end

endmodule

// ===== testbench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("wrong value at %0t got %h exp %h", $time, a, e); end end
module testbench;
    reg         clk_in = 1'b0;
    reg         rst_in = 1'b0;
    reg  [7:0]  src = 8'h00;
    reg  [7:0]  q;
    int         i, num_errors = 0, total_checks = 0;
    wire [15:0] addr_in;
    wire [7:0]  data_in, data_out, bank_sel_n_out;
    wire [13:0] rom_addr_out;
    wire        mreq_n_in, iorq_n_in, rd_n_in, wr_n_in, m1_n_in;
    wire        rom_sel_n_out, ram_sel_n_out, disp_rd_n_out, int_n_out;
    wire        disp_wr_n_out, data_oe_out;
    wire        rom_ovl_out;
    always #25 clk_in = ~clk_in;
    sdip_glue sdip_glue_inst (.*, .disk_data_request(src[0]),
        .disk_command_complete(src[1]), .video_done_in(src[2]),
        .keyboard_data_in(src[3]), .timer_tick_in(src[4]),
        .expansion_card_one(src[5]), .expansion_card_two(src[6]),
        .expansion_bus_connector(src[7]));
    sdip_cpu_model sdip_cpu_model_inst (.clk_in(clk_in), .rd_data_in(data_out),
        .addr_out(addr_in), .data_out(data_in), .mreq_n_out(mreq_n_in),
        .iorq_n_out(iorq_n_in), .rd_n_out(rd_n_in), .wr_n_out(wr_n_in),
        .m1_n_out(m1_n_in));
    task results;
        begin
            $display("checks %0d errors %0d", total_checks, num_errors);
            if (num_errors == 0 && total_checks > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    initial begin
        rst_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        sdip_cpu_model_inst.cyc(3'h0, 16'h3FFF, 8'h00, q);
        `CHK({rom_ovl_out, rom_sel_n_out, ram_sel_n_out}, 3'h5)
        `CHK(rom_addr_out, 14'h3FFF)
        sdip_cpu_model_inst.cyc(3'h0, 16'h8000, 8'h00, q);
        `CHK({rom_sel_n_out, ram_sel_n_out}, 2'h2)
        for (i = 0; i < 8; i++) begin
            sdip_cpu_model_inst.cyc(3'h1, {10'h000, i[2:0], 3'h7}, 8'h00, q);
            `CHK(bank_sel_n_out, ~(8'h01 << i))
        end
        sdip_cpu_model_inst.cyc(3'h1, 16'h0040, 8'h00, q);
        `CHK(bank_sel_n_out, 8'hFF)
        sdip_cpu_model_inst.cyc(3'h0, 16'h0010, 8'h00, q);
        `CHK(bank_sel_n_out, 8'hFF)
        sdip_cpu_model_inst.cyc(3'h1, 16'h000D, 8'h00, q);
        `CHK(disp_rd_n_out, 1'b0)
        sdip_cpu_model_inst.cyc(3'h3, 16'h001C, 8'h00, q);
        `CHK({disp_wr_n_out, disp_rd_n_out}, 2'h1)
        for (i = 0; i < 2; i++) begin
            sdip_cpu_model_inst.cyc(3'h3, 16'h0018, i[7:0], q);
            sdip_cpu_model_inst.cyc(3'h0, 16'h7FFF, 8'h00, q);
            `CHK({rom_ovl_out, rom_sel_n_out, ram_sel_n_out}, {i[0], ~i[0], i[0]})
        end
        src <= 8'h88;
        sdip_cpu_model_inst.cyc(3'h1, 16'h0018, 8'h00, q);
        `CHK(q, 8'h88)
        `CHK(data_oe_out, 1'b1)
        for (i = 0; i < 8; i++) begin
            src <= 8'hFF << i;
            sdip_cpu_model_inst.cyc(3'h4, 16'h0000, 8'h00, q);
            `CHK({int_n_out, data_oe_out, q}, {2'h1, i[6:0], 1'b0})
        end
        sdip_cpu_model_inst.cyc(3'h3, 16'h001D, 8'hFE, q);
        src <= 8'h03;
        sdip_cpu_model_inst.cyc(3'h4, 16'h0000, 8'h00, q);
        `CHK(q, 8'h02)
        src <= 8'h01;
        sdip_cpu_model_inst.cyc(3'h0, 16'h8000, 8'h00, q);
        `CHK(int_n_out, 1'b1)
        results;
    end
endmodule
